// ---- core/wdt_top.sv ----
// Windowed watchdog timer with AXI4-Lite registers.
// Assumes SYS_RST is synchronous and POR_IN marks a power-on reset.
// Functional notes
// R1: Software configures within 128 clocks after reset.
// R2: A602 then B480 restarts counter.
// R3: Second service word late forces reset.
// R4: Counter reaching timeout forces reset.
// R5: Early service in window mode forces reset.
// R6: Configuration registers accept one write only.
// R7: New configuration applies once all written.
// R8: Window registers optional when window disabled.
// R9: Update bit allows unlock-based reconfiguration.
// R10: C520 then D928 within 16 clocks unlocks.
// R11: Unlock without reconfiguration in 128 resets.
// R12: Four selectable counter clock sources.
// R13: Optional divide by 256 before counting.
// R14: Default timeout is about 4 ms.
// R15: Source change holds counter 2.5+2.5 periods.
// R16: Interrupt first, reset 128 clocks later.
// R17: Without interrupt, reset is immediate.
// R18: Two overflows on slow source reset.
// R19: Halt, idle, deep sleep stop counting.
// R20: Deep sleep gives reset, never interrupt.
// R21: Halt and deep sleep need non-bus source.
// R22: Fast test runs counter bytes separately.
// R23: Power-on reset sets the power-on flag.
// R24: Clock select codes 00,01,10,11.
// R25: Other counter writes force reset.
// R26: Test select 10 low, 11 high.
// R27: Only power-on reset clears test select.
// R28: Counter ticks, compares, clears on service.
`timescale 1ns/10ps
module wdt_top import wdt_pkg::*; #(
    parameter int CFG_WIN = CFG_CLKS,
    parameter int IRQ_WAIT = IRQ_CLKS
) (
    // Clock and resets.
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic POR_IN,
    // Processor mode levels.
    input wire logic DEBUG_HALT,
    input wire logic IDLE_MODE,
    input wire logic DEEP_SLEEP_MODE,
    // Counter clock pins.
    input wire logic LPO_CLK,
    input wire logic IRC_CLK,
    input wire logic EXT_CLK,
    // AXI4-Lite write channels.
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read channels.
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Watchdog outputs.
    output logic WDT_IRQ,
    output logic WDT_RESET_REQ
);
    typedef struct packed {
        logic awr, wrr, aw_got, w_got, bv, arr, rv;
        logic [7:0] awa;
        logic [31:0] wd, rd;
        logic [3:0] ws;
        logic [1:0] br, rr;
        logic [7:0] cs1w, cs2w, cs1a, cs2a;
        logic [15:0] tovw, winw, tova, wina, cnt;
        logic [3:0] wr, hc;
        logic [1:0] tst, ovf, old_sel;
        logic cfg_open, done, unl;
        logic [7:0] cfg_cnt, dly;
        wdt_seq_e seq;
        logic [4:0] sq_cnt;
        wdt_hold_e hold;
        logic flag, pend, rst_req, irq, por;
    } wdt_top_s;
    wdt_top_s r, n;
    logic [3:0] edg;
    logic tick;
    logic wfire, viol, svc, unl_ok, apply, tout, run, need;

    // Counts must fit their 8-bit counters.
    if (CFG_WIN < 2 || CFG_WIN > 256 || IRQ_WAIT < 2 || IRQ_WAIT > 256)
    begin : g_chk
        $error("wdt_top: CFG_WIN and IRQ_WAIT must be 2 to 256");
    end

    function automatic logic is_reg(input logic [7:0] a);
        return a inside {A_CS1, A_CS2, A_CNT, A_TOV, A_WIN, A_STS};
    endfunction

    // Byte lanes not strobed keep the old value.
    function automatic logic [31:0] wmask(input logic [31:0] o,
        input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                o[8 * i +: 8] = d[8 * i +: 8];
            end
        end
        return o;
    endfunction

    // Half periods per edge: the bus clock gives one cycle per edge seen.
    function automatic logic [3:0] hstep(input logic [1:0] s);
        return (s == CS_BUS) ? 4'h2 : 4'h1;
    endfunction

    // Source pins, synchronised and prescaled.
    wdt_tick u_tick (
        .clk(CLK),
        .rst(SYS_RST),
        .src_pin({EXT_CLK, IRC_CLK, LPO_CLK}),
        .sel(r.cs2a[C2_CLK +: 2]),
        .div256(r.cs2a[C2_DIVIDE_BY_256_ENABLE]),
        .edge_o(edg),
        .tick_o(tick)
    );

    // Next state of bus slave, configuration, counter and reset logic.
    always_comb begin
        logic [15:0] w;
        logic [1:0] sel;
        logic ext;
        w = r.wd[15:0];
        sel = r.cs2a[C2_CLK +: 2];
        ext = sel != CS_BUS;
        n = r;
        wfire = 1'b0;
        viol = 1'b0;
        svc = 1'b0;
        unl_ok = 1'b0;
        // Address and data are taken in either order.
        if (AWVALID && r.awr) begin
            n.awa = AWADDR;
            n.aw_got = 1'b1;
            n.awr = 1'b0;
        end
        if (WVALID && r.wrr) begin
            n.wd = WDATA;
            n.ws = WSTRB;
            n.w_got = 1'b1;
            n.wrr = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bv) begin
            wfire = 1'b1;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bv = 1'b1;
            n.br = is_reg(r.awa) ? R_OKAY : R_SLVERR;
        end
        if (r.bv && BREADY) begin
            n.bv = 1'b0;
            n.awr = 1'b1;
            n.wrr = 1'b1;
        end
        // Reads have no side effects.
        if (ARVALID && r.arr) begin
            n.arr = 1'b0;
            n.rv = 1'b1;
            n.rr = is_reg(ARADDR) ? R_OKAY : R_SLVERR;
            unique case (ARADDR)
                A_CS1: n.rd = {24'h0, r.tst, r.cs1a[5:0]};
                A_CS2: n.rd = {24'h0, r.cs2a & C2_MASK} | 32'h40 * r.flag;
                A_CNT: n.rd = {16'h0, r.cnt};
                A_TOV: n.rd = {16'h0, r.tova};
                A_WIN: n.rd = {16'h0, r.wina};
                A_STS: n.rd = {26'h0, r.rst_req, r.pend,
                    r.hold != HD_NONE, r.cfg_open, r.done, r.por};
                default: n.rd = 32'h0;
            endcase
        end
        if (r.rv && RREADY) begin
            n.rv = 1'b0;
            n.arr = 1'b1;
        end
        // Write-once configuration, open only in the window.
        if (wfire && r.cfg_open) begin
            if (r.awa == A_CS1 && !r.wr[0]) begin // R6
                n.cs1w = 8'(wmask({24'h0, r.cs1w}, r.wd, r.ws));
                n.wr[0] = 1'b1;
            end
            if (r.awa == A_CS2 && !r.wr[1]) begin // R6
                n.cs2w = 8'(wmask({24'h0, r.cs2w}, r.wd, r.ws)) & C2_MASK;
                n.wr[1] = 1'b1;
            end
            if (r.awa == A_TOV && !r.wr[2]) begin // R6
                n.tovw = 16'(wmask({16'h0, r.tovw}, r.wd, r.ws));
                n.wr[2] = 1'b1;
            end
            if (r.awa == A_WIN && !r.wr[3]) begin // R6
                n.winw = 16'(wmask({16'h0, r.winw}, r.wd, r.ws));
                n.wr[3] = 1'b1;
            end
        end
        // Write-one-to-clear flags; a same-cycle set below still wins.
        if (wfire && r.awa == A_CS2 && r.wd[C2_FLG] && r.ws[0]) begin
            n.flag = 1'b0;
        end
        if (wfire && r.awa == A_STS && r.wd[0] && r.ws[0]) begin
            n.por = 1'b0;
        end
        // Counter pair: only service and unlock pairs are legal.
        if (wfire && r.awa == A_CNT) begin
            n.seq = SQ_IDLE;
            n.sq_cnt = 5'h0;
            unique case (r.seq)
                SQ_IDLE: begin
                    if (w == SVC1) begin
                        if (r.cs2a[C2_WIN] && r.cnt < r.wina) begin
                            viol = 1'b1; // R5
                        end else begin
                            n.seq = SQ_SVC; // R2
                        end
                    end else if (w == UNL1 && r.done && r.cs1a[C1_UPD]) begin
                        n.seq = SQ_UNL; // R9 R10
                    end else begin
                        viol = 1'b1; // R25
                    end
                end
                SQ_SVC: begin
                    svc = w == SVC2; // R2
                    viol = w != SVC2; // R25
                end
                SQ_UNL: begin
                    unl_ok = w == UNL2; // R10
                    viol = w != UNL2; // R25
                end
            endcase
        end else if (r.seq != SQ_IDLE) begin
            if (r.sq_cnt == 5'(SEQ_CLKS - 1)) begin
                viol = 1'b1; // R3 R10
                n.seq = SQ_IDLE;
            end else begin
                n.sq_cnt = r.sq_cnt + 5'h1;
            end
        end
        // Apply once control, timeout and, if needed, window are written.
        need = r.wr[0] && r.wr[1] && r.wr[2]
            && (r.wr[3] || !r.cs2w[C2_WIN]); // R8
        apply = r.cfg_open && !r.done && need; // R7
        if (apply) begin
            n.cs1a = r.cs1w;
            n.cs2a = r.cs2w;
            n.tova = r.tovw;
            n.wina = r.wr[3] ? r.winw : r.wina;
            n.tst = r.cs1w[C1_TST +: 2];
            n.done = 1'b1;
            if (r.unl && r.cs2w[C2_CLK +: 2] != sel) begin
                n.old_sel = sel; // R15
                n.hold = HD_WAIT;
                n.hc = 4'h0;
            end
        end
        // Configuration window of CFG_WIN bus clocks.
        if (r.cfg_open) begin
            if (r.cfg_cnt == 8'(CFG_WIN - 1)) begin
                n.cfg_open = 1'b0; // R1
                n.unl = 1'b0;
                if (r.unl && !r.done && !apply) begin
                    viol = 1'b1; // R11
                end
            end else begin
                n.cfg_cnt = r.cfg_cnt + 8'h01;
            end
        end
        if (unl_ok) begin
            n.cfg_open = 1'b1; // R9
            n.cfg_cnt = 8'h0;
            n.wr = 4'h0;
            n.done = 1'b0;
            n.unl = 1'b1;
        end
        // Hold after a source change: old source first, then the new.
        unique case (r.hold)
            HD_NONE: ;
            HD_WAIT: if (!r.cfg_open) n.hold = HD_OLD; // R15
            HD_OLD: begin
                if (edg[r.old_sel]) begin
                    n.hc = r.hc + hstep(r.old_sel);
                end
                if (r.hc >= 4'(HOLD_HALVES)) begin
                    n.hc = 4'h0;
                    n.hold = HD_NEW; // R15
                end
            end
            HD_NEW: begin
                if (edg[sel]) begin
                    n.hc = r.hc + hstep(sel);
                end
                if (r.hc >= 4'(HOLD_HALVES)) begin
                    n.hold = HD_NONE; // R15
                end
            end
        endcase
        // Counting stops in low-power and halt modes unless enabled; halt and deep sleep also need a non-bus source.
        run = r.cs1a[C1_EN] && r.hold == HD_NONE
            && !(DEBUG_HALT && !(r.cs1a[C1_DBG] && ext)) // R19 R21
            && !(IDLE_MODE && !r.cs1a[C1_IDLE]) // R19
            && !(DEEP_SLEEP_MODE && !(r.cs1a[C1_DEEP] && ext)); // R21
        if (run && tick) begin
            if (r.tst == TST_LOW) begin
                n.cnt = {8'h0, r.cnt[7:0] + 8'h01}; // R22 R26
            end else if (r.tst == TST_HIGH && r.cnt[7]) begin
                n.cnt = {r.cnt[15:8] + 8'h01, 8'h0}; // R22 R26
            end else begin
                n.cnt = r.cnt + 16'h1; // R28
            end
            if (r.cnt == 16'hffff && ext) begin
                n.ovf = 2'h1;
                viol = viol || r.ovf != 2'h0; // R18
            end
        end
        if (r.hold inside {HD_OLD, HD_NEW}) begin
            n.cnt = 16'h0; // R15
        end
        if (svc) begin
            n.cnt = 16'h0; // R2 R28
            n.ovf = 2'h0;
        end
        // Byte-wise compare in fast test, full compare otherwise.
        if (r.tst == TST_LOW) begin
            tout = r.cnt[7:0] == r.tova[7:0]; // R22
        end else if (r.tst == TST_HIGH) begin
            tout = r.cnt[15:8] == r.tova[15:8]; // R22
        end else begin
            tout = r.cnt == r.tova; // R4 R28
        end
        tout = tout && r.cs1a[C1_EN] && r.hold == HD_NONE;
        viol = viol || tout; // R4
        // First event wins; deep sleep never takes the interrupt path.
        if (viol && !r.pend && !r.rst_req) begin
            if (r.cs1a[C1_INT] && !DEEP_SLEEP_MODE) begin
                n.pend = 1'b1; // R16
                n.dly = 8'h0;
                n.flag = 1'b1;
            end else begin
                n.rst_req = 1'b1; // R17 R20
            end
        end
        if (r.pend) begin
            if (r.dly == 8'(IRQ_WAIT - 1)) begin
                n.rst_req = 1'b1; // R16
            end else begin
                n.dly = r.dly + 8'h01;
            end
        end
        n.irq = n.flag && n.cs1a[C1_INT] && !DEEP_SLEEP_MODE; // R20
    end

    // Reset keeps the test select unless it is a power-on reset.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            r <= '0;
            r.awr <= 1'b1;
            r.wrr <= 1'b1;
            r.arr <= 1'b1;
            r.cs1w <= CS1_DEF;
            r.cs2w <= CS2_DEF; // R14
            r.tovw <= TOV_DEF;
            r.cs1a <= CS1_DEF;
            r.cs2a <= CS2_DEF; // R12 R14
            r.tova <= TOV_DEF; // R14
            r.cfg_open <= 1'b1;
            r.seq <= SQ_IDLE;
            r.hold <= HD_NONE;
            r.tst <= POR_IN ? 2'h0 : r.tst; // R27
            r.por <= POR_IN; // R23
        end else begin
            r <= n;
        end
    end

    assign AWREADY = r.awr;
    assign WREADY = r.wrr;
    assign BRESP = r.br;
    assign BVALID = r.bv;
    assign ARREADY = r.arr;
    assign RDATA = r.rd;
    assign RRESP = r.rr;
    assign RVALID = r.rv;
    assign WDT_IRQ = r.irq;
    assign WDT_RESET_REQ = r.rst_req;

    // Decode of the first service word for the early-refresh check.
    logic w_is_svc1;
    assign w_is_svc1 = r.wd[15:0] == SVC1;

    // Checks on the watchdog decisions.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    property p_svc;
        svc |=> r.cnt == 16'h0;
    endproperty
    a_svc: assert property (p_svc) else $error("service kept count"); // R2
    property p_late;
        r.seq == SQ_SVC && r.sq_cnt == 5'(SEQ_CLKS - 1) && !wfire |-> viol;
    endproperty
    a_late: assert property (p_late) else $error("late word missed"); // R3
    property p_tout;
        tout && !r.pend && !r.rst_req && !r.cs1a[C1_INT] |=> WDT_RESET_REQ;
    endproperty
    a_tout: assert property (p_tout) else $error("no timeout reset"); // R4
    property p_early;
        wfire && r.awa == A_CNT && w_is_svc1 && r.seq == SQ_IDLE
            && r.cs2a[C2_WIN] && r.cnt < r.wina |-> viol;
    endproperty
    a_early: assert property (p_early) else $error("early svc missed"); // R5
    property p_once;
        r.wr[0] |=> $stable(r.cs1w);
    endproperty
    a_once: assert property (p_once) else $error("second write took"); // R6
    property p_apply;
        $changed(r.cs2a) |-> $past(apply);
    endproperty
    a_apply: assert property (p_apply) else $error("config not gated"); // R7
    property p_unl;
        r.cfg_open && r.unl && !r.done && !apply
            && r.cfg_cnt == 8'(CFG_WIN - 1) |-> viol;
    endproperty
    a_unl: assert property (p_unl) else $error("unlock left open"); // R11
    property p_dly;
        $rose(r.pend) |-> !WDT_RESET_REQ ##IRQ_WAIT $rose(WDT_RESET_REQ);
    endproperty
    a_dly: assert property (p_dly) else $error("reset delay wrong"); // R16
    property p_halt;
        DEBUG_HALT && !r.cs1a[C1_DBG] && !svc
            && r.hold == HD_NONE |=> $stable(r.cnt);
    endproperty
    a_halt: assert property (p_halt) else $error("counted in halt"); // R19
    property p_deep;
        DEEP_SLEEP_MODE |=> !WDT_IRQ;
    endproperty
    a_deep: assert property (p_deep) else $error("irq in deep sleep"); // R20
    c_svc: cover property (svc);
    c_pend: cover property ($rose(r.pend));
    c_reapply: cover property (apply && r.unl);
    c_hold: cover property (r.hold == HD_NEW);
endmodule

// ---- core/wdt_pkg.sv ----
// Shared constants and state types of the windowed watchdog timer.
// Assumes one 100 MHz bus clock and an AXI4-Lite register port.
package wdt_pkg;
    // Register byte offsets.
    localparam logic [7:0] A_CS1 = 8'h00;
    localparam logic [7:0] A_CS2 = 8'h04;
    localparam logic [7:0] A_CNT = 8'h08;
    localparam logic [7:0] A_TOV = 8'h0c;
    localparam logic [7:0] A_WIN = 8'h10;
    localparam logic [7:0] A_STS = 8'h14;
    // Service and unlock words written to the counter pair.
    localparam logic [15:0] SVC1 = 16'ha602;
    localparam logic [15:0] SVC2 = 16'hb480;
    localparam logic [15:0] UNL1 = 16'hc520;
    localparam logic [15:0] UNL2 = 16'hd928;
    // Timing in bus clocks; the hold counts half periods (2.5 periods).
    localparam int CFG_CLKS = 128;
    localparam int SEQ_CLKS = 16;
    localparam int IRQ_CLKS = 128;
    localparam int HOLD_HALVES = 5;
    localparam int PRESCALE = 256;
    // Clock source codes.
    localparam logic [1:0] CS_BUS = 2'h0;
    localparam logic [1:0] CS_LPO = 2'h1;
    localparam logic [1:0] CS_IRC = 2'h2;
    localparam logic [1:0] CS_EXT = 2'h3;
    // Field positions of control_status_one.
    localparam int C1_UPD = 0;
    localparam int C1_INT = 1;
    localparam int C1_DBG = 2;
    localparam int C1_IDLE = 3;
    localparam int C1_DEEP = 4;
    localparam int C1_EN = 5;
    localparam int C1_TST = 6;
    // Field positions of control_status_two.
    localparam int C2_CLK = 0;
    localparam int C2_DIVIDE_BY_256_ENABLE = 4;
    localparam int C2_FLG = 6;
    localparam int C2_WIN = 7;
    localparam logic [7:0] C2_MASK = 8'h93;
    // Self-test select codes.
    localparam logic [1:0] TST_LOW = 2'h2;
    localparam logic [1:0] TST_HIGH = 2'h3;
    // Reset defaults: about 4 ms on the 1 kHz oscillator.
    localparam int DEF_TIMEOUT_MS = 4;
    localparam int LPO_HZ = 1000;
    localparam logic [15:0] TOV_DEF = 16'(DEF_TIMEOUT_MS * LPO_HZ / 1000);
    localparam logic [7:0] CS1_DEF = 8'h20;
    localparam logic [7:0] CS2_DEF = 8'h01;
    // AXI responses.
    localparam logic [1:0] R_OKAY = 2'h0;
    localparam logic [1:0] R_SLVERR = 2'h2;
    // Service sequence and clock-switch hold states.
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001, SQ_SVC = 3'b010, SQ_UNL = 3'b100
    } wdt_seq_e;
    typedef enum logic [3:0] {
        HD_NONE = 4'b0001, HD_WAIT = 4'b0010,
        HD_OLD = 4'b0100, HD_NEW = 4'b1000
    } wdt_hold_e;
endpackage

// ---- core/wdt_tick.sv ----
// Clock source synchroniser, edge finder and divide-by-256 prescaler.
// Assumes the slow clock pins are asynchronous and below half of CLK.
`timescale 1ns/10ps
module wdt_tick import wdt_pkg::*; (
    // Bus clock and synchronous reset.
    input wire logic clk,
    input wire logic rst,
    // Raw pins: external, 32 kHz and 1 kHz from top to bottom.
    input wire logic [2:0] src_pin,
    // Source select and prescaler enable.
    input wire logic [1:0] sel,
    input wire logic div256,
    // One pulse per edge of each source; bit 0 is the bus clock.
    output logic [3:0] edge_o,
    // One pulse per counter increment.
    output logic tick_o
);
    typedef struct packed {
        logic [2:0] s1, s2, s3, lvl;
        logic [7:0] pre;
        logic [3:0] edg;
        logic tick;
    } wdt_tick_s;
    wdt_tick_s r, n;

    // A pin change counts once stages two and three agree, which costs
    // latency but keeps a metastable first stage out of the decision.
    always_comb begin
        logic [3:0] rise;
        rise = 4'h1;
        n = r;
        n.s1 = src_pin;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.edg = 4'h1;
        n.tick = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (r.s2[i] == r.s3[i] && r.s3[i] != r.lvl[i]) begin
                n.lvl[i] = r.s3[i];
                n.edg[i + 1] = 1'b1;
                rise[i + 1] = r.s3[i];
            end
        end
        // The selected source clocks the counter, through the prescaler.
        if (rise[sel]) begin // R12 R24
            n.pre = r.pre + 8'h01;
            n.tick = !div256 || r.pre == 8'(PRESCALE - 1); // R13
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign edge_o = r.edg;
    assign tick_o = r.tick;
endmodule

// ---- testbench/test_windowed_watchdog_timer.sv ----
// Self-checking bench of the windowed watchdog over AXI4-Lite.
// Assumes wdt_top with a short interrupt wait and a 100 MHz CLK.
`timescale 1ns/10ps
module test_windowed_watchdog_timer;
    import wdt_pkg::*;
    localparam int IW = 16;
    logic CLK = 0, SYS_RST = 1, POR_IN = 1, LPO_CLK = 0, IRC_CLK = 0;
    logic DEBUG_HALT = 0, DEEP_SLEEP_MODE = 0;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [7:0] AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, RDATA, rv;
    logic [3:0] WSTRB = 4'hf;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WDT_IRQ, WDT_RESET_REQ;
    logic [1:0] BRESP, RRESP, rsp;
    int err_total = 0, check_count = 0, n;

    // Slow sources are sped up so the default timeout fits the run.
    always #5 CLK = ~CLK;
    always #500 LPO_CLK = ~LPO_CLK;
    always #700 IRC_CLK = ~IRC_CLK;

    // Idle mode stays low; the external pin is left idle.
    wdt_top #(.IRQ_WAIT(IW)) i_dut (.CLK(CLK), .SYS_RST(SYS_RST),
        .POR_IN(POR_IN), .DEBUG_HALT(DEBUG_HALT), .IDLE_MODE(1'b0),
        .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE), .LPO_CLK(LPO_CLK),
        .IRC_CLK(IRC_CLK),
        .EXT_CLK(1'b0), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .WDT_IRQ(WDT_IRQ), .WDT_RESET_REQ(WDT_RESET_REQ));

    task automatic conclude();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A wait that runs out ends the run at once.
    task automatic tmo(string nm);
        err_total++;
        $display("Error %s expected event seen none", nm);
        conclude();
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Each channel is released at the edge that takes it.
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) break;
        end
        if (n == 40) tmo("write response");
        rsp = BRESP;
        BREADY <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID) break;
        end
        if (n == 40) tmo("read response");
        rv = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
    endtask

    task automatic wait_req(int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge CLK);
            if (WDT_RESET_REQ === 1'b1) break;
        end
        if (n == lim) tmo("reset request");
    endtask

    task automatic rst(logic por);
        @(posedge CLK);
        POR_IN <= por;
        SYS_RST <= 1'b1;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
    endtask

    task automatic t_defaults();
        rd(A_CS1);
        chk("cs1 default", {24'h0, CS1_DEF}, rv);
        rd(A_CS2);
        chk("cs2 default", {24'h0, CS2_DEF}, rv);
        rd(A_TOV);
        chk("timeout default", {16'h0, TOV_DEF}, rv);
        rd(A_STS);
        chk("power-on flag", 1, rv[0]);
        rd(8'h18);
        chk("unmapped resp", R_SLVERR, rsp);
        chk("unmapped data", 0, rv);
    endtask

    // Window left disabled, so its registers are never written.
    task automatic t_config();
        wr(A_TOV, 32'h100);
        wr(A_CS2, {30'h0, CS_BUS});
        rd(A_STS);
        chk("applied early", 0, rv[1]);
        wr(A_CS1, 32'h21);
        rd(A_STS);
        chk("applied", 1, rv[1]);
        wr(A_TOV, 32'h50);
        chk("ignored write resp", R_OKAY, rsp);
        rd(A_TOV);
        chk("timeout once", 32'h100, rv);
    endtask

    task automatic t_service();
        repeat (60) @(posedge CLK);
        rd(A_CNT);
        chk("counting", 1, rv[15:0] > 16'd40);
        wr(A_CNT, {16'h0, SVC1});
        wr(A_CNT, {16'h0, SVC2});
        rd(A_CNT);
        chk("count cleared", 1, rv[15:0] < 16'd12);
        chk("no reset", 0, WDT_RESET_REQ);
    endtask

    task automatic t_unlock();
        wr(A_CNT, {16'h0, UNL1});
        wr(A_CNT, {16'h0, UNL2});
        wr(A_TOV, 32'h40);
        wr(A_CS2, {30'h0, CS_BUS});
        wr(A_CS1, 32'h22);
        rd(A_TOV);
        chk("reconfigured", 32'h40, rv);
        chk("no unlock reset", 0, WDT_RESET_REQ);
    endtask

    // The timeout is left to expire with the interrupt first.
    task automatic t_irq();
        for (n = 0; n < 300; n++) begin
            @(posedge CLK);
            if (WDT_IRQ === 1'b1) break;
        end
        if (n == 300) tmo("interrupt");
        chk("reset deferred", 0, WDT_RESET_REQ);
        wait_req(IW + 4);
        chk("irq delay", 1, n >= IW - 2 && n <= IW + 1);
    endtask

    task automatic t_late();
        logic [31:0] v;
        rd(A_STS);
        chk("power-on clear", 0, rv[0]);
        DEBUG_HALT <= 1'b1;
        rd(A_CNT);
        v = rv;
        repeat (250) @(posedge CLK);
        rd(A_CNT);
        chk("halted count", v, rv);
        DEBUG_HALT <= 1'b0;
        wr(A_CNT, {16'h0, SVC1});
        repeat (SEQ_CLKS - 6) @(posedge CLK);
        chk("late not yet", 0, WDT_RESET_REQ);
        wait_req(12);
    endtask

    task automatic t_illegal();
        wr(A_CNT, 32'h1234);
        wait_req(4);
        chk("immediate reset", 1, n <= 2);
    endtask

    // Full configuration with the early-refresh window at 0x80.
    task automatic cfg(logic [7:0] c1);
        wr(A_TOV, 32'h100);
        wr(A_WIN, 32'h80);
        wr(A_CS2, 32'h80);
        wr(A_CS1, {24'h0, c1});
        rd(A_STS);
        chk("window applied", 1, rv[1]);
    endtask

    // Unlock, then leave the reopened window unused.
    task automatic t_unl_late();
        cfg(8'h21);
        wr(A_CNT, {16'h0, UNL1});
        wr(A_CNT, {16'h0, UNL2});
        wait_req(CFG_CLKS + 4);
        chk("unlock timeout", 1, n >= CFG_CLKS - 3 && n <= CFG_CLKS);
    endtask

    // Early service in deep sleep: reset at once, no interrupt.
    task automatic t_window();
        cfg(8'h22);
        DEEP_SLEEP_MODE <= 1'b1;
        wr(A_CNT, {16'h0, SVC1});
        wait_req(4);
        chk("early reset", 1, n <= 2);
        chk("no deep irq", 0, WDT_IRQ);
    endtask

    // Main sequence; later resets are not power-on resets.
    initial begin
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_defaults();
        t_config();
        t_service();
        t_unlock();
        t_irq();
        rst(1'b0);
        t_late();
        rst(1'b0);
        t_illegal();
        rst(1'b0);
        t_unl_late();
        rst(1'b0);
        t_window();
        conclude();
    end
endmodule
